/* File: rtl/spid_phase.v */
/*
 one phase of the split-phase detector: load-biased compare, minimum
 load supervision and the continuous-pickup delay timer.
 assumes all inputs come from logic on pclk; currents in 0.001 pu.
*/
`timescale 1ns/1ns
`include "spid_defines.vh"

module spid_phase #(
	parameter CYC_PER_MS = `SPID_CYC_PER_MS
) (
	input wire pclk,
	input wire presetn,
	input wire [15:0] split_cur,
	input wire [15:0] load_cur,
	input wire [10:0] pickup,
	input wire [9:0] offset,
	input wire [9:0] slope,
	input wire [6:0] min_load,
	input wire [15:0] delay_ms,
	input wire mode,
	input wire blk,
	output wire op_d,
	output reg pickup_q,
	output reg op_q
);

// ----------------------------------------------------------------
// compare, scaled by 1000 so the slope division is exact
// ----------------------------------------------------------------
wire [27:0] split_k = {12'h000, split_cur} * {18'h00000, `SPID_FULL_SCALE};
wire [27:0] slope_load = {18'h00000, slope} * {12'h000, load_cur};
wire [27:0] off_k = {18'h00000, offset} * {18'h00000, `SPID_FULL_SCALE};
wire [27:0] pk_k = {17'h00000, pickup} * {18'h00000, `SPID_FULL_SCALE};
wire [27:0] bias_k = slope_load + off_k;
wire over = split_k > bias_k + pk_k;
wire under = split_k + pk_k < bias_k;
wire [15:0] min_mpu = {9'h000, min_load} * {12'h000, `SPID_MINLOAD_SCALE};
wire load_ok = load_cur >= min_mpu;
wire pk_d = load_ok & (over | (mode == `SPID_MODE_OVER_UNDER & under)) & ~blk;

// ----------------------------------------------------------------
// delay timer: restarts whenever pickup drops
// ----------------------------------------------------------------
reg [16:0] cyc_q;
reg [15:0] ms_q;
wire done = ms_q >= delay_ms;
assign op_d = pk_d & done;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		cyc_q <= 17'h00000;
		ms_q <= 16'h0000;
		pickup_q <= 1'b0;
		op_q <= 1'b0;
	end else begin
		pickup_q <= pk_d;
		op_q <= op_d;
		if (!pk_d) begin
			cyc_q <= 17'h00000;
			ms_q <= 16'h0000;
		end else if (!done) begin
			if (cyc_q == CYC_PER_MS[16:0] - 17'h00001) begin
				cyc_q <= 17'h00000;
				ms_q <= ms_q + 16'h0001;
			end else begin
				cyc_q <= cyc_q + 17'h00001;
			end
		end
	end
end

endmodule // spid_phase

/* File: rtl/spid_top.v */
/*
 split-phase inter-turn detector top: apb settings registers, source
 selection, three phase comparators, interrupt status.
 assumes measurement magnitudes and the block input come from logic on
 pclk, so they are not synchronised; apb master per amba apb.
*/
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "spid_defines.vh"

module spid_top #(
	parameter CYC_PER_MS = `SPID_CYC_PER_MS
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [191:0] split_mag,
	input wire [63:0] load_mag,
	input wire element_block_input,
	output wire [2:0] phase_pickup,
	output wire [2:0] phase_operate,
	output reg operate,
	output reg irq
);

// ----------------------------------------------------------------
// settings registers
// ----------------------------------------------------------------
reg [1:0] split_src_q;
reg [1:0] load_src_q;
reg mode_q;
reg [6:0] min_load_q;
reg [15:0] delay_q;
reg [32:0] pickup_q;
reg [29:0] offset_q;
reg [29:0] slope_q;
reg [3:0] irq_stat_q;
reg [3:0] irq_en_q;
reg [2:0] pk_prev_q;
reg op_prev_q;

// ----------------------------------------------------------------
// apb decode; slave answers one cycle into the access phase
// ----------------------------------------------------------------
wire acc = psel & penable & ~pready;
wire fire = psel & penable & pready;
wire wr = fire & pwrite;
wire [5:0] ofs = paddr[5:0];
wire hit = (paddr[7:6] == 2'b00) & (paddr[1:0] == 2'b00) &
	(ofs <= `SPID_OFS_IRQ_CLR);
wire [31:0] wd = pwdata;

function [10:0] clamp11;
	input [31:0] v;
	input [10:0] mx;
	begin
		clamp11 = (v > {21'h000000, mx}) ? mx : v[10:0];
	end
endfunction

wire [10:0] wd_pickup = clamp11(wd, `SPID_MAX_PICKUP);
wire [10:0] wd_offset = clamp11(wd, {1'b0, `SPID_MAX_OFFSET});
wire [10:0] wd_slope = clamp11(wd, {1'b0, `SPID_MAX_SLOPE});
wire [10:0] wd_minload = clamp11(wd, {4'h0, `SPID_MAX_MINLOAD});

// ----------------------------------------------------------------
// phases
// ----------------------------------------------------------------
wire [47:0] split_grp = split_mag[split_src_q * 48 +: 48];
wire [15:0] load_cur = load_mag[load_src_q * 16 +: 16];
wire [2:0] op_d;
wire [3:0] events;

genvar g;
generate
	for (g = 0; g < 3; g = g + 1) begin : ph
		spid_phase #(
			.CYC_PER_MS(CYC_PER_MS)
		) u_phase (
			.pclk(pclk),
			.presetn(presetn),
			.split_cur(split_grp[g*16 +: 16]),
			.load_cur(load_cur),
			.pickup(pickup_q[g*11 +: 11]),
			.offset(offset_q[g*10 +: 10]),
			.slope(slope_q[g*10 +: 10]),
			.min_load(min_load_q),
			.delay_ms(delay_q),
			.mode(mode_q),
			.blk(element_block_input),
			.op_d(op_d[g]),
			.pickup_q(phase_pickup[g]),
			.op_q(phase_operate[g])
		);
	end
endgenerate

assign events = {operate & ~op_prev_q, phase_pickup & ~pk_prev_q};
wire [3:0] irq_clr = (wr & hit & (ofs == `SPID_OFS_IRQ_CLR)) ? wd[3:0] : 4'h0;
wire [3:0] irq_stat_d = (irq_stat_q & ~irq_clr) | events; // set wins over clear

// ----------------------------------------------------------------
// read mux
// ----------------------------------------------------------------
reg [31:0] rd_d;
always @* begin
	rd_d = 32'h00000000;
	case (ofs)
		`SPID_OFS_CTRL: rd_d = {27'h0000000, mode_q, load_src_q, split_src_q};
		`SPID_OFS_MINLOAD: rd_d = {25'h0000000, min_load_q};
		`SPID_OFS_DELAY: rd_d = {16'h0000, delay_q};
		`SPID_OFS_PICKUP_A: rd_d = {21'h000000, pickup_q[10:0]};
		`SPID_OFS_PICKUP_B: rd_d = {21'h000000, pickup_q[21:11]};
		`SPID_OFS_PICKUP_C: rd_d = {21'h000000, pickup_q[32:22]};
		`SPID_OFS_OFFSET_A: rd_d = {22'h000000, offset_q[9:0]};
		`SPID_OFS_OFFSET_B: rd_d = {22'h000000, offset_q[19:10]};
		`SPID_OFS_OFFSET_C: rd_d = {22'h000000, offset_q[29:20]};
		`SPID_OFS_SLOPE_A: rd_d = {22'h000000, slope_q[9:0]};
		`SPID_OFS_SLOPE_B: rd_d = {22'h000000, slope_q[19:10]};
		`SPID_OFS_SLOPE_C: rd_d = {22'h000000, slope_q[29:20]};
		`SPID_OFS_STATUS: rd_d = {25'h0000000, operate, phase_operate, phase_pickup};
		`SPID_OFS_IRQ_STAT: rd_d = {28'h0000000, irq_stat_q};
		`SPID_OFS_IRQ_EN: rd_d = {28'h0000000, irq_en_q};
		default: rd_d = 32'h00000000;
	endcase
end

// ----------------------------------------------------------------
// sequential
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata <= 32'h00000000;
		pready <= 1'b0;
		pslverr <= 1'b0;
		split_src_q <= `SPID_RST_SPLIT_SRC;
		load_src_q <= `SPID_RST_LOAD_SRC;
		mode_q <= `SPID_MODE_OVER;
		min_load_q <= `SPID_RST_MINLOAD;
		delay_q <= `SPID_RST_DELAY;
		pickup_q <= {3{`SPID_RST_PICKUP}};
		offset_q <= {3{`SPID_RST_OFFSET}};
		slope_q <= {3{`SPID_RST_SLOPE}};
		irq_stat_q <= 4'h0;
		irq_en_q <= 4'h0;
		pk_prev_q <= 3'h0;
		op_prev_q <= 1'b0;
		operate <= 1'b0;
		irq <= 1'b0;
	end else begin
		pready <= acc;
		pslverr <= acc & ~hit;
		prdata <= (acc & hit & ~pwrite) ? rd_d : 32'h00000000;
		operate <= |op_d;
		pk_prev_q <= phase_pickup;
		op_prev_q <= operate;
		irq_stat_q <= irq_stat_d;
		irq <= |(irq_stat_d & irq_en_q);
		if (wr & hit) begin
			case (ofs)
				`SPID_OFS_CTRL: begin
					split_src_q <= wd[`SPID_CTRL_SPLIT_LSB +: 2];
					load_src_q <= wd[`SPID_CTRL_LOAD_LSB +: 2];
					mode_q <= wd[`SPID_CTRL_MODE_BIT];
				end
				`SPID_OFS_MINLOAD: min_load_q <= wd_minload[6:0];
				`SPID_OFS_DELAY: delay_q <= wd[15:0];
				`SPID_OFS_PICKUP_A: pickup_q[10:0] <= wd_pickup;
				`SPID_OFS_PICKUP_B: pickup_q[21:11] <= wd_pickup;
				`SPID_OFS_PICKUP_C: pickup_q[32:22] <= wd_pickup;
				`SPID_OFS_OFFSET_A: offset_q[9:0] <= wd_offset[9:0];
				`SPID_OFS_OFFSET_B: offset_q[19:10] <= wd_offset[9:0];
				`SPID_OFS_OFFSET_C: offset_q[29:20] <= wd_offset[9:0];
				`SPID_OFS_SLOPE_A: slope_q[9:0] <= wd_slope[9:0];
				`SPID_OFS_SLOPE_B: slope_q[19:10] <= wd_slope[9:0];
				`SPID_OFS_SLOPE_C: slope_q[29:20] <= wd_slope[9:0];
				`SPID_OFS_IRQ_EN: irq_en_q <= wd[3:0];
				default: irq_en_q <= irq_en_q;
			endcase
		end
	end
end

endmodule // spid_top

/* File: shared/spid_defines.vh */
/*
 constants for the split-phase inter-turn detector: register offsets,
 field positions, reset values, setting limits and timing counts.
 assumes inclusion by bare name from files under rtl/.
*/
`ifndef SPID_DEFINES_VH
`define SPID_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SPID_OFS_CTRL 6'h00
`define SPID_OFS_MINLOAD 6'h04
`define SPID_OFS_DELAY 6'h08
`define SPID_OFS_PICKUP_A 6'h0C
`define SPID_OFS_PICKUP_B 6'h10
`define SPID_OFS_PICKUP_C 6'h14
`define SPID_OFS_OFFSET_A 6'h18
`define SPID_OFS_OFFSET_B 6'h1C
`define SPID_OFS_OFFSET_C 6'h20
`define SPID_OFS_SLOPE_A 6'h24
`define SPID_OFS_SLOPE_B 6'h28
`define SPID_OFS_SLOPE_C 6'h2C
`define SPID_OFS_STATUS 6'h30
`define SPID_OFS_IRQ_STAT 6'h34
`define SPID_OFS_IRQ_EN 6'h38
`define SPID_OFS_IRQ_CLR 6'h3C

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define SPID_CTRL_SPLIT_LSB 0
`define SPID_CTRL_LOAD_LSB 2
`define SPID_CTRL_MODE_BIT 4
`define SPID_MODE_OVER 1'b0
`define SPID_MODE_OVER_UNDER 1'b1

// ----------------------------------------------------------------
// reset values and limits (pickup/offset in 0.001 pu, slope 0.1 %, min load 0.01 pu)
// ----------------------------------------------------------------
`define SPID_RST_SPLIT_SRC 2'h0
`define SPID_RST_LOAD_SRC 2'h1
`define SPID_RST_PICKUP 11'h0C8
`define SPID_MAX_PICKUP 11'h5DC
`define SPID_RST_OFFSET 10'h000
`define SPID_MAX_OFFSET 10'h3E8
`define SPID_RST_SLOPE 10'h000
`define SPID_MAX_SLOPE 10'h3E8
`define SPID_RST_MINLOAD 7'h00
`define SPID_MAX_MINLOAD 7'h64
`define SPID_MINLOAD_SCALE 4'hA
`define SPID_RST_DELAY 16'h0000
`define SPID_FULL_SCALE 10'h3E8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SPID_DELAY_STEP_NS 1000000
`define SPID_CLK_NS 8
`define SPID_CYC_PER_MS (`SPID_DELAY_STEP_NS / `SPID_CLK_NS)

`endif

/* File: tb/spid_src_model.sv */
/* measurement source model: one chosen split source and one chosen load source.
   assumes the bench changes its values just after a rising edge. */
`timescale 1ns/1ns
module spid_src_model (
	input wire pclk,
	input wire [1:0] ssel,
	input wire [1:0] lsel,
	input wire [47:0] split_v,
	input wire [15:0] load_v,
	output reg [191:0] split_mag,
	output reg [63:0] load_mag
);
	integer s;
	// unselected sources carry the inverse, so a wrong select cannot pass unseen
	always @(posedge pclk) begin
		for (s = 0; s < 4; s = s + 1) begin
			split_mag[s*48+:48] <= (s == ssel) ? split_v : ~split_v;
			load_mag[s*16+:16] <= (s == lsel) ? load_v : ~load_v;
		end
	end
endmodule // spid_src_model

/* File: tb/spid_top_sva.sv */
/* port checker for spid_top.
   assumes a bind onto spid_top; sees its ports only. */
`timescale 1ns/1ns
module spid_top_sva (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire element_block_input,
	input wire [2:0] phase_pickup,
	input wire [2:0] phase_operate,
	input wire operate
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup; psel && !penable; endsequence
	sequence s_first; s_setup ##1 (psel && penable); endsequence
	a_ready_wait: assert property (s_first |=> pready) else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
	a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
	a_data_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
	a_block_clears: assert property (element_block_input |=> (phase_pickup | phase_operate) == 3'h0)
		else $error("outputs active while blocked");
	a_block_holds: assert property (element_block_input [*2] |-> !operate) else $error("operate while blocked");
	a_operate_or: assert property (operate == |phase_operate) else $error("operate not or");
	a_op_pick: assert property ((phase_operate & ~phase_pickup) == 3'h0) else $error("operate without pickup");
endmodule // spid_top_sva
bind spid_top spid_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .element_block_input(element_block_input), .phase_pickup(phase_pickup),
	.phase_operate(phase_operate), .operate(operate));

/* File: tb/tb_split_phase_interturn_detector.sv */
/* self-checking bench for spid_top with a source model.
   assumes apb timing and reset values as handed over. */
`timescale 1ns/1ns
module tb_split_phase_interturn_detector;
	localparam C = 10;
	reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, blk = 0, se, md;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0, rd;
	reg [1:0] ssel = 2'h0, lsel = 2'h1;
	reg [47:0] split_v = 48'h0;
	reg [15:0] load_v = 16'h0;
	reg [2:0] e;
	wire [191:0] split_mag;
	wire [63:0] load_mag;
	wire [31:0] prdata;
	wire pready, pslverr, operate, irq;
	wire [2:0] pk, op;
	integer err_count = 0, check_count = 0, i, j, n, t, ml, ld, pv[0:2], ov[0:2], sv[0:2], sp[0:2];
	always #4 pclk = ~pclk;
	spid_src_model u_src (.pclk(pclk), .ssel(ssel), .lsel(lsel), .split_v(split_v), .load_v(load_v),
		.split_mag(split_mag), .load_mag(load_mag));
	spid_top #(.CYC_PER_MS(C)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.split_mag(split_mag), .load_mag(load_mag), .element_block_input(blk), .phase_pickup(pk),
		.phase_operate(op), .operate(operate), .irq(irq));
	task chk(input [31:0] seen, input [31:0] exp, input [8*16-1:0] what);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("ERROR %0s expected %0h seen %0h", what, exp, seen);
			end
		end
	endtask
	// waits for pready, so no fixed latency is assumed
	task apb(input wr, input [7:0] a, input [31:0] d);
		begin
			psel <= 1'b1;
			pwrite <= wr;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk) penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1) begin
				@(posedge pclk);
			end
			rd = prdata;
			se = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	function exp_pk(input integer s, l, p, o, sl, m, input md);
		exp_pk = (l >= 10*m) && ((1000*s > sl*l + 1000*(o+p)) || (md && 1000*(s+p) < sl*l + 1000*o));
	endfunction
	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", check_count, err_count);
			if (err_count == 0 && check_count > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	initial begin
		#400000;
		err_count = err_count + 1;
		end_of_test;
	end
	initial begin
		n = $urandom(74);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		for (i = 0; i < 12; i = i + 1) begin
			apb(0, 8'(4*i), 0);
			chk(rd, i == 0 ? 32'h4 : (i > 2 && i < 6) ? 32'hC8 : 32'h0, "reset value");
		end
		for (i = 0; i < 4; i = i + 1) begin
			apb(1, 8'(i == 0 ? 4 : 12*i), 32'hFFFF);
			apb(0, 8'(i == 0 ? 4 : 12*i), 0);
			chk(rd, i == 0 ? 32'h64 : i == 1 ? 32'h5DC : 32'h3E8, "clamp");
		end
		apb(0, 8'h40, 0);
		chk(se, 1, "unmapped err");
		chk(rd, 0, "unmapped data");
		$display("settings test done");
		for (n = 0; n < 40; n = n + 1) begin
			md = $urandom % 2;
			ml = $urandom % 101;
			ld = $urandom % 2000;
			j = $urandom % 16;
			apb(1, 8'h00, {27'h0, md, j[3:0]});
			apb(1, 8'h04, ml);
			for (i = 0; i < 3; i = i + 1) begin
				pv[i] = $urandom % 1501;
				ov[i] = $urandom % 1001;
				sv[i] = $urandom % 1001;
				t = (sv[i]*ld)/1000 + ov[i] + ((n % 2) ? pv[i] : -pv[i]) + $urandom % 7 - 3;
				sp[i] = (n % 3 == 2 || t < 0) ? $urandom % 4000 : t;
				e[i] = exp_pk(sp[i], ld, pv[i], ov[i], sv[i], ml, md);
				apb(1, 8'(12 + 4*i), pv[i]);
				apb(1, 8'(24 + 4*i), ov[i]);
				apb(1, 8'(36 + 4*i), sv[i]);
			end
			ssel <= j[1:0];
			lsel <= j[3:2];
			load_v <= ld[15:0];
			split_v <= {sp[2][15:0], sp[1][15:0], sp[0][15:0]};
			repeat (4) @(posedge pclk);
			chk({operate, op, pk}, {|e, e, e}, "pickup");
		end
		$display("compare test done");
		presetn <= 1'b0;
		ssel <= 2'h0;
		lsel <= 2'h1;
		split_v <= 48'h0;
		load_v <= 16'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1, 8'h08, 3);
		apb(1, 8'h38, 8);
		for (j = 0; j < 2; j = j + 1) begin
			split_v <= 48'd1000;
			t = 0;
			while (pk[0] !== 1'b1 && t < 50) begin
				t = t + 1;
				@(posedge pclk);
			end
			n = 0;
			while (op[0] !== 1'b1 && n < 100) begin
				n = n + 1;
				@(posedge pclk);
			end
			chk(n >= 3*C && n <= 3*C + 2, 1, "delay");
			repeat (3) @(posedge pclk);
			chk(irq, 1, "irq raised");
			split_v <= 48'h0;
			repeat (3) @(posedge pclk);
			chk({operate, op}, 0, "drop");
			apb(1, 8'h3C, 32'hF);
			chk(irq, 0, "irq cleared");
		end
		$display("delay test done");
		apb(1, 8'h38, 0);
		split_v <= 48'd1000;
		repeat (40) @(posedge pclk);
		chk(irq, 0, "irq masked");
		apb(0, 8'h34, 0);
		chk(rd, 32'h9, "irq status");
		blk <= 1'b1;
		repeat (2) @(posedge pclk);
		chk({operate, op, pk}, 0, "blocked");
		blk <= 1'b0;
		repeat (3) @(posedge pclk);
		chk({op, pk}, 6'h01, "timer cleared");
		$display("block test done");
		end_of_test;
	end
endmodule // tb_split_phase_interturn_detector
